// *** core/dfg_pkg.sv ***
// Shared constants, types and helpers of the fairness and terminal-count gate.
package dfg_pkg;

  localparam int unsigned NREQ          = 4;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned CFG_W         = 8;
  localparam int unsigned FAIR_BIT      = 7;
  localparam logic [ADDR_W-1:0] EN_ADDR = 16'h02F7;
  localparam logic [NREQ-1:0] EN_RESET  = 4'h0;
  localparam logic [NREQ-1:0] REQ_NONE  = 4'h0;
  localparam logic [NREQ-1:0] REQ_ONE   = 4'h1;

  // Request slots: 0 receive_req_a, 1 receive_req_b, 2 transmit_req_a, 3 transmit_req_b.
  localparam int unsigned SLOT_RX_A = 0;
  localparam int unsigned SLOT_RX_B = 1;
  localparam int unsigned SLOT_TX_A = 2;
  localparam int unsigned SLOT_TX_B = 3;

  typedef enum logic [1:0] {
    FS_IDLE,
    FS_SERVE,
    FS_WAIT,
    FS_TEMP
  } dfg_fair_state_t;

  typedef struct packed {
    logic              chreset;
    logic [CFG_W-1:0]  option_cfg;
    logic              preempt;
    logic [NREQ-1:0]   ready;
    logic              io_read_strobe;
    logic              io_write_strobe;
    logic              port_a_select;
    logic              port_b_select;
    logic [ADDR_W-1:0] io_addr;
    logic [NREQ-1:0]   io_data;
    logic              tc;
    logic              line_err_a;
    logic              line_err_b;
    logic              flag_ack;
  } dfg_pins_t;

  // Rising edge of each bit of a vector against its previous sample.
  function automatic logic [NREQ-1:0] dfg_rise(input logic [NREQ-1:0] cur,
                                               input logic [NREQ-1:0] prev);
    dfg_rise = cur & ~prev;
  endfunction : dfg_rise

endpackage : dfg_pkg

// *** core/dfg_fair_if.sv ***
// Signals shared between the gate control and the four fairness machines.
`timescale 1ns/1ps
interface dfg_fair_if;
  import dfg_pkg::*;
  logic            chreset;
  logic            fair_en;
  logic            preempt;
  logic [NREQ-1:0] req;
  logic [NREQ-1:0] degate;

  modport ctrl (output chreset, output fair_en, output preempt, output req, input degate);
  modport fsm  (input chreset, input fair_en, input preempt, input req, output degate);
endinterface : dfg_fair_if

// *** core/dfg_fair_fsm.sv ***
// One fairness machine that degates its own request while others wait.
`timescale 1ns/1ps
module dfg_fair_fsm
  import dfg_pkg::*;
#(
  parameter int unsigned IDX = 0
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  dfg_fair_if.fsm  bus
);

  localparam logic [NREQ-1:0] OWN_MASK = REQ_ONE << IDX;

  dfg_fair_state_t state_reg;
  dfg_fair_state_t state_next;
  logic            degate_reg;
  logic            degate_next;
  wire logic       own_req;
  wire logic       others_act;
  wire logic       hold_off;

  assign own_req    = |(bus.req & OWN_MASK);
  assign others_act = (|(bus.req & ~OWN_MASK)) | bus.preempt;
  assign hold_off   = bus.fair_en & others_act;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FS_IDLE: begin
        if (own_req) begin
          state_next = FS_SERVE;
        end
      end
      FS_SERVE: begin
        if (!own_req) begin
          state_next = hold_off ? FS_WAIT : FS_IDLE;
        end
      end
      FS_WAIT: begin
        if (!bus.fair_en) begin
          state_next = FS_IDLE;
        end else if (!others_act) begin
          state_next = FS_TEMP;
        end
      end
      FS_TEMP: begin
        state_next = FS_IDLE;
      end
      default: begin
        state_next = FS_IDLE;
      end
    endcase
  end

  assign degate_next = bus.fair_en & ((state_next == FS_WAIT) | (state_next == FS_TEMP));

  always_ff @(posedge i_clk) begin
    if (!i_nrst || bus.chreset) begin
      state_reg  <= FS_IDLE;
      degate_reg <= 1'h0;
    end else begin
      state_reg  <= state_next;
      degate_reg <= degate_next;
    end
  end

  assign bus.degate[IDX] = degate_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking

  reset_idle_a: assert property (disable iff (!i_nrst) bus.chreset |=>
      state_reg == FS_IDLE && !degate_reg) else $error("machine not idle after channel reset");
  idle_quiet_a: assert property (disable iff (!i_nrst)
      state_reg == FS_IDLE |-> !degate_reg) else $error("degate driven in idle");
  serve_first_a: assert property (disable iff (!i_nrst || bus.chreset)
      state_reg == FS_WAIT && $past(state_reg) != FS_WAIT |-> $past(state_reg) == FS_SERVE)
      else $error("wait entered without serving");
  wait_entry_a: assert property (disable iff (!i_nrst || bus.chreset)
      state_reg == FS_SERVE && !own_req && hold_off |=> state_reg == FS_WAIT && degate_reg)
      else $error("finished request not degated");
  wait_hold_a: assert property (disable iff (!i_nrst || bus.chreset)
      state_reg == FS_WAIT && hold_off |=> state_reg == FS_WAIT && degate_reg)
      else $error("wait left while others active");
  temp_release_a: assert property (disable iff (!i_nrst || bus.chreset)
      state_reg == FS_WAIT && bus.fair_en && !others_act |=> state_reg == FS_TEMP && degate_reg
      ##1 state_reg == FS_IDLE && !degate_reg) else $error("release through temp broken");
  serve_idle_a: assert property (disable iff (!i_nrst || bus.chreset)
      state_reg == FS_SERVE && !own_req && !hold_off |=> state_reg == FS_IDLE && !degate_reg)
      else $error("degate without waiting party");
  fair_off_a: assert property (disable iff (!i_nrst)
      !bus.fair_en |=> !degate_reg) else $error("degate while fairness disabled");

  wait_seen_c: cover property (disable iff (!i_nrst) state_reg == FS_TEMP ##1 state_reg == FS_IDLE);

endmodule : dfg_fair_fsm

// *** core/dfg_gate_top.sv ***
// Fairness gating and terminal-count handling for four UART DMA requests.
//
// Overview of operation
// - Fairness acts only when configuration bit 7 set.
// - Four machines, each seeing the same seven inputs.
// - Request passes only if enabled and not degated.
// - Channel reset idles machines; idle drives no degate.
// - Own request moves idle to serving state.
// - Finish with others waiting: wait and degate.
// - Wait while others active, release through temp.
// - Finished channel barred until all others finish.
// - Terminal count decoded per channel by strobes, selects.
// - Decoded terminal count clears that channel's enable.
// - Terminal count raises interrupt and sets status flag.
// - Line status errors also drive the interrupt.
// - Write-only four-bit enable register at 2F7h.
// - Machines see active-high enable-gated ready signals.
`timescale 1ns/1ps
module dfg_gate_top
  import dfg_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_NRST,
  input  wire logic              I_CHRESET,
  input  wire logic [CFG_W-1:0]  I_OPTION_CFG,
  input  wire logic              I_PREEMPT,
  input  wire logic              I_UART_RECEIVE_READY_A,
  input  wire logic              I_UART_RECEIVE_READY_B,
  input  wire logic              I_UART_TRANSMIT_READY_A,
  input  wire logic              I_UART_TRANSMIT_READY_B,
  input  wire logic              I_IO_READ_STROBE,
  input  wire logic              I_IO_WRITE_STROBE,
  input  wire logic              I_PORT_A_SELECT,
  input  wire logic              I_PORT_B_SELECT,
  input  wire logic [ADDR_W-1:0] I_IO_ADDR,
  input  wire logic [NREQ-1:0]   I_IO_DATA,
  input  wire logic              I_TC,
  input  wire logic              I_LINE_ERR_A,
  input  wire logic              I_LINE_ERR_B,
  input  wire logic              I_TC_FLAG_ACK,
  output logic      [NREQ-1:0]   O_REQ_GATED,
  output logic      [NREQ-1:0]   O_WAIT_DEGATE,
  output logic      [NREQ-1:0]   O_REQ_ENABLE,
  output logic                   O_TC_FLAG,
  output logic                   O_SHARED_IRQ_LINE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser for every pin except clock and reset.

  dfg_pins_t       pins_raw;
  dfg_pins_t       pins_meta_reg;
  dfg_pins_t       pins_reg;
  logic            wr_prev_reg;
  logic [NREQ-1:0] tc_term_prev_reg;
  logic [NREQ-1:0] enable_reg;
  logic [NREQ-1:0] enable_next;
  logic            tc_flag_reg;
  logic            tc_flag_next;
  logic            irq_reg;
  logic            irq_next;
  logic [NREQ-1:0] req_gated_reg;
  logic [NREQ-1:0] req_gated_next;

  assign pins_raw.chreset         = I_CHRESET;
  assign pins_raw.option_cfg      = I_OPTION_CFG;
  assign pins_raw.preempt         = I_PREEMPT;
  assign pins_raw.ready[SLOT_RX_A] = I_UART_RECEIVE_READY_A;
  assign pins_raw.ready[SLOT_RX_B] = I_UART_RECEIVE_READY_B;
  assign pins_raw.ready[SLOT_TX_A] = I_UART_TRANSMIT_READY_A;
  assign pins_raw.ready[SLOT_TX_B] = I_UART_TRANSMIT_READY_B;
  assign pins_raw.io_read_strobe  = I_IO_READ_STROBE;
  assign pins_raw.io_write_strobe = I_IO_WRITE_STROBE;
  assign pins_raw.port_a_select   = I_PORT_A_SELECT;
  assign pins_raw.port_b_select   = I_PORT_B_SELECT;
  assign pins_raw.io_addr         = I_IO_ADDR;
  assign pins_raw.io_data         = I_IO_DATA;
  assign pins_raw.tc              = I_TC;
  assign pins_raw.line_err_a      = I_LINE_ERR_A;
  assign pins_raw.line_err_b      = I_LINE_ERR_B;
  assign pins_raw.flag_ack        = I_TC_FLAG_ACK;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      pins_meta_reg <= '0;
      pins_reg      <= '0;
    end else begin
      pins_meta_reg <= pins_raw;
      pins_reg      <= pins_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding of the enable write and the per-channel terminal count.

  wire logic            chreset;
  wire logic            fair_en;
  wire logic            wr_rise;
  wire logic            en_write_hit;
  wire logic [NREQ-1:0] tc_term;
  wire logic [NREQ-1:0] tc_pulse;
  wire logic            tc_any;
  wire logic            line_err;
  wire logic [NREQ-1:0] req_en;
  wire logic [NREQ-1:0] degate;

  assign chreset      = pins_reg.chreset;
  assign fair_en      = pins_reg.option_cfg[FAIR_BIT];
  assign wr_rise      = pins_reg.io_write_strobe & ~wr_prev_reg;
  assign en_write_hit = wr_rise & (pins_reg.io_addr == EN_ADDR);

  assign tc_term[SLOT_RX_A] = pins_reg.tc & pins_reg.io_read_strobe & pins_reg.port_a_select;
  assign tc_term[SLOT_RX_B] = pins_reg.tc & pins_reg.io_read_strobe & pins_reg.port_b_select;
  assign tc_term[SLOT_TX_A] = pins_reg.tc & pins_reg.io_write_strobe & pins_reg.port_a_select;
  assign tc_term[SLOT_TX_B] = pins_reg.tc & pins_reg.io_write_strobe & pins_reg.port_b_select;

  assign tc_pulse = dfg_rise(tc_term, tc_term_prev_reg);
  assign tc_any   = |tc_pulse;
  assign line_err = pins_reg.line_err_a | pins_reg.line_err_b;

  ////////////////////////////////////////////////////////////////////////////////
  // Enable register, status flag and shared interrupt.

  assign enable_next = chreset ? EN_RESET :
                       ((en_write_hit ? pins_reg.io_data : enable_reg) & ~tc_pulse);

  assign tc_flag_next = chreset                ? 1'h0 :
                        tc_any                 ? 1'h1 :
                        pins_reg.flag_ack      ? 1'h0 :
                        tc_flag_reg;

  assign irq_next = tc_flag_next | line_err;

  assign req_en         = pins_reg.ready & enable_reg;
  assign req_gated_next = req_en & ~degate;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      wr_prev_reg      <= 1'h0;
      tc_term_prev_reg <= REQ_NONE;
      enable_reg       <= EN_RESET;
      tc_flag_reg      <= 1'h0;
      irq_reg          <= 1'h0;
      req_gated_reg    <= REQ_NONE;
    end else begin
      wr_prev_reg      <= pins_reg.io_write_strobe;
      tc_term_prev_reg <= tc_term;
      enable_reg       <= enable_next;
      tc_flag_reg      <= tc_flag_next;
      irq_reg          <= irq_next;
      req_gated_reg    <= req_gated_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fairness machines.

  dfg_fair_if fair_bus ();

  assign fair_bus.chreset = chreset;
  assign fair_bus.fair_en = fair_en;
  assign fair_bus.preempt = pins_reg.preempt;
  assign fair_bus.req     = req_en;
  assign degate           = fair_bus.degate;

  genvar g;
  generate
    for (g = 0; g < NREQ; g++) begin : g_fair
      dfg_fair_fsm #(
        .IDX (g)
      ) u_fsm (
        .i_clk  (I_CLK),
        .i_nrst (I_NRST),
        .bus    (fair_bus.fsm)
      );
    end
  endgenerate

  assign O_REQ_GATED       = req_gated_reg;
  assign O_WAIT_DEGATE     = degate;
  assign O_REQ_ENABLE      = enable_reg;
  assign O_TC_FLAG         = tc_flag_reg;
  assign O_SHARED_IRQ_LINE = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  tc_clear_en_a: assert property (tc_any |=> (enable_reg & $past(tc_pulse)) == REQ_NONE)
    else $error("terminal count did not clear enable");

  tc_sets_flag_a: assert property (tc_any && !chreset |=> tc_flag_reg && O_SHARED_IRQ_LINE)
    else $error("terminal count did not raise flag and interrupt");

  err_irq_a: assert property (line_err |=> O_SHARED_IRQ_LINE)
    else $error("line error did not drive interrupt");

  flag_hold_a: assert property (tc_flag_reg && !pins_reg.flag_ack && !chreset |=> tc_flag_reg)
    else $error("status flag dropped without acknowledge");

  chreset_clear_a: assert property (chreset |=> enable_reg == EN_RESET && !tc_flag_reg)
    else $error("channel reset left state behind");

  en_write_a: assert property (en_write_hit && !chreset |=>
      enable_reg == ($past(pins_reg.io_data) & ~$past(tc_pulse)))
    else $error("enable register write lost");

  gate_pass_a: assert property ((req_gated_reg & ~($past(pins_reg.ready) & $past(enable_reg)
      & ~$past(degate))) == REQ_NONE)
    else $error("request passed while disabled or degated");

  tc_decode_a: assert property (tc_pulse[SLOT_RX_A] |->
      pins_reg.tc && pins_reg.io_read_strobe && pins_reg.port_a_select)
    else $error("terminal count attributed to wrong channel");

  tc_seen_c:     cover property (tc_any ##1 tc_flag_reg);
  degate_seen_c: cover property (|degate);
  err_irq_c:     cover property (line_err ##1 O_SHARED_IRQ_LINE);
  all_en_c:      cover property (enable_reg == ~REQ_NONE);

endmodule : dfg_gate_top

// *** test/dfg_host_model.sv ***
// Host DMA controller and bus arbiter model driving the gate's bus pins.
`timescale 1ns/1ps
module dfg_host_model
  import dfg_pkg::*;
(
  input  wire logic              i_clk,
  output logic                   o_chreset,
  output logic                   o_preempt,
  output logic                   o_rd,
  output logic                   o_wr,
  output logic                   o_sel_a,
  output logic                   o_sel_b,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [NREQ-1:0]   o_data,
  output logic                   o_tc
);
  initial begin
    {o_chreset, o_preempt, o_rd, o_wr, o_sel_a, o_sel_b, o_tc} = 7'h00;
    o_addr = 16'h0000;
    o_data = 4'h0;
  end

  // Released address and data lines show the inverse of their last value.
  task automatic io_write(input logic [ADDR_W-1:0] a, input logic [NREQ-1:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_data <= d;
    o_wr   <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_wr   <= 1'b0;
    o_addr <= ~a;
    o_data <= ~d;
  endtask : io_write

  // Terminal count rides on the final strobe of the serviced port.
  task automatic xfer(input logic rd, input logic b, input logic t, input logic s);
    @(posedge i_clk);
    o_addr  <= 16'h02F8;
    o_rd    <= rd & s;
    o_wr    <= ~rd & s;
    o_sel_a <= ~b & s;
    o_sel_b <= b & s;
    o_tc    <= t;
    repeat (2) @(posedge i_clk);
    {o_rd, o_wr, o_sel_a, o_sel_b, o_tc} <= 5'h00;
    o_addr  <= 16'hFD07;
  endtask : xfer

  task automatic set_line(input logic cr, input logic pe);
    @(posedge i_clk);
    o_chreset <= cr;
    o_preempt <= pe;
  endtask : set_line
endmodule : dfg_host_model

// *** test/tb.sv ***
// Self-checking bench of the fairness and terminal-count gate.
`timescale 1ns/1ps
module tb;
  import dfg_pkg::*;
  logic              clk  = 1'b0;
  logic              nrst = 1'b0;
  logic [CFG_W-1:0]  cfg  = 8'h00;
  logic [NREQ-1:0]   rdy  = 4'h0;
  logic [1:0]        err  = 2'h0;
  logic              ack  = 1'b0;
  logic              chr, pre, rd, wr, sa, sb, tc, flag, irq;
  logic [ADDR_W-1:0] addr;
  logic [NREQ-1:0]   data, gated, degate, en;
  logic [NREQ-1:0]   m_en   = 4'h0;
  logic              m_flag = 1'b0;
  int                m_st [NREQ] = '{0, 0, 0, 0};
  int                num_errors = 0;
  int                n_compared = 0;

  always #5 clk = ~clk;

  dfg_host_model host (.i_clk(clk), .o_chreset(chr), .o_preempt(pre), .o_rd(rd),
    .o_wr(wr), .o_sel_a(sa), .o_sel_b(sb), .o_addr(addr), .o_data(data), .o_tc(tc));

  dfg_gate_top dut (.I_CLK(clk), .I_NRST(nrst), .I_CHRESET(chr), .I_OPTION_CFG(cfg),
    .I_PREEMPT(pre), .I_UART_RECEIVE_READY_A(rdy[0]), .I_UART_RECEIVE_READY_B(rdy[1]),
    .I_UART_TRANSMIT_READY_A(rdy[2]), .I_UART_TRANSMIT_READY_B(rdy[3]),
    .I_IO_READ_STROBE(rd), .I_IO_WRITE_STROBE(wr), .I_PORT_A_SELECT(sa),
    .I_PORT_B_SELECT(sb), .I_IO_ADDR(addr), .I_IO_DATA(data), .I_TC(tc),
    .I_LINE_ERR_A(err[0]), .I_LINE_ERR_B(err[1]), .I_TC_FLAG_ACK(ack),
    .O_REQ_GATED(gated), .O_WAIT_DEGATE(degate), .O_REQ_ENABLE(en),
    .O_TC_FLAG(flag), .O_SHARED_IRQ_LINE(irq));

  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatches", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk_vec(input string n, input logic [NREQ-1:0] e, input logic [NREQ-1:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_vec

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  // Advances the reference machines to rest and compares every output.
  task automatic settle();
    logic [NREQ-1:0] req;
    logic [NREQ-1:0] dg;
    logic            oth;
    logic            fair;
    repeat (8) @(posedge clk);
    fair = cfg[FAIR_BIT];
    req  = rdy & m_en;
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < NREQ; i++) begin
        oth = (|(req & ~(REQ_ONE << i))) | pre;
        case (m_st[i])
          0: m_st[i] = req[i] ? 1 : 0;
          1: m_st[i] = req[i] ? 1 : ((fair && oth) ? 2 : 0);
          2: m_st[i] = !fair ? 0 : (oth ? 2 : 3);
          default: m_st[i] = 0;
        endcase
        dg[i] = fair && m_st[i] >= 2;
      end
    end
    chk_vec("degate", dg, degate);
    chk_vec("gated", rdy & m_en & ~dg, gated);
    chk_vec("enable", m_en, en);
    chk_bit("flag", m_flag, flag);
    chk_bit("irq", m_flag | err[0] | err[1], irq);
  endtask : settle

  task automatic drive(input logic [CFG_W-1:0] c, input logic [NREQ-1:0] r, input logic [1:0] e);
    @(posedge clk);
    cfg <= c;
    rdy <= r;
    err <= e;
    settle();
  endtask : drive

  task automatic wr_en(input logic [ADDR_W-1:0] a, input logic [NREQ-1:0] d);
    host.io_write(a, d);
    if (a == EN_ADDR) m_en = d;
    settle();
  endtask : wr_en

  task automatic tc_xfer(input logic r, input logic b, input logic t, input logic s);
    host.xfer(r, b, t, s);
    if (t && s) begin
      m_en[{~r, b}] = 1'b0;
      m_flag = 1'b1;
    end
    settle();
  endtask : tc_xfer

  task automatic flag_ack();
    @(posedge clk);
    ack <= 1'b1;
    repeat (2) @(posedge clk);
    ack <= 1'b0;
    m_flag = 1'b0;
    settle();
  endtask : flag_ack

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end

  initial begin
    void'($urandom(4404));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    settle();
    $display("Test reset done");
    wr_en(16'h02F6, 4'hF);
    wr_en(EN_ADDR, 4'h5);
    wr_en(EN_ADDR, 4'hF);
    $display("Test enable done");
    drive(8'h80, 4'h3, 2'h0);
    drive(8'h80, 4'h2, 2'h0);
    drive(8'h80, 4'h3, 2'h0);
    drive(8'h80, 4'h1, 2'h0);
    drive(8'h80, 4'h0, 2'h0);
    host.set_line(1'b0, 1'b1);
    drive(8'h80, 4'h1, 2'h0);
    drive(8'h80, 4'h0, 2'h0);
    host.set_line(1'b0, 1'b0);
    drive(8'h80, 4'h0, 2'h0);
    drive(8'h00, 4'h3, 2'h0);
    drive(8'h00, 4'h2, 2'h0);
    $display("Test fairness done");
    for (int j = 0; j < 24; j++) begin
      fork
        host.set_line(1'b0, 1'($urandom));
        drive(8'($urandom), 4'($urandom), 2'h0);
      join
    end
    host.set_line(1'b0, 1'b0);
    drive(8'h80, 4'h0, 2'h0);
    $display("Test random done");
    for (int j = 0; j < 4; j++) begin
      wr_en(EN_ADDR, 4'hF);
      tc_xfer(j < 2, j[0], 1'b1, 1'b1);
      settle();
      flag_ack();
    end
    tc_xfer(1'b1, 1'b0, 1'b1, 1'b0);
    tc_xfer(1'b0, 1'b1, 1'b0, 1'b1);
    drive(8'h80, 4'h0, 2'h1);
    drive(8'h80, 4'h0, 2'h2);
    drive(8'h80, 4'h0, 2'h0);
    $display("Test terminal count done");
    wr_en(EN_ADDR, 4'hF);
    tc_xfer(1'b0, 1'b0, 1'b1, 1'b1);
    drive(8'h80, 4'h3, 2'h0);
    host.set_line(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    host.set_line(1'b0, 1'b0);
    m_en = EN_RESET;
    m_flag = 1'b0;
    m_st = '{0, 0, 0, 0};
    settle();
    $display("Test channel reset done");
    conclude();
  end
endmodule : tb
